// File: core/usb_mgr_pkg.sv
// Shared constants and types of the USB interface manager register block
package usb_mgr_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_SOFT_RESET = 8'h00;
	localparam logic [7:0] OFF_MODE_CTRL = 8'h04;
	localparam logic [7:0] OFF_DEV_ADDR = 8'h08;
	localparam logic [7:0] OFF_FUNC_CTRL = 8'h0C;
	localparam logic [7:0] OFF_OTG_CTRL = 8'h10;
	localparam logic [7:0] OFF_OTG_STAT = 8'h14;
	localparam logic [7:0] OFF_SERIAL = 8'h18;
	localparam logic [7:0] OFF_FLAGS = 8'h1C;
	localparam logic [7:0] OFF_HOLD = 8'h20;
	localparam logic [7:0] OFF_PORT_MASK = 8'h24;
	localparam logic [7:0] OFF_SOF = 8'h28;
	localparam logic [7:0] OFF_PID = 8'h2C;
	localparam logic [7:0] OFF_ENDPOINT = 8'h30;
	localparam logic [7:0] OFF_EP_MATCH = 8'h34;
	localparam logic [7:0] OFF_OTG_MASK = 8'h38;
	localparam logic [7:0] OFF_POWER = 8'h3C;
	localparam logic [7:0] OFF_PHY_CTRL = 8'h40;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE_TOKEN_PROCESS = 0;
	localparam int MODE_TOKEN_CHECK = 1;
	localparam int MODE_LINE_DECODE = 2;
	localparam int MODE_FRAME_AS_TOKEN = 6;
	localparam int FLAG_TOKEN = 6;
	localparam int FLAG_SE0 = 5;
	localparam int FLAG_K = 4;
	localparam int FLAG_J = 3;
	localparam int FLAG_CRC16 = 2;
	localparam int FLAG_RXACTIVE = 1;
	localparam int FLAG_RXERROR = 0;
	// ----------------------------------------
	// Write masks and reset values
	// ----------------------------------------
	localparam logic [7:0] MODE_WMASK = 8'hF7;
	localparam logic [7:0] OTG_WMASK = 8'hDF;
	localparam logic [3:0] SERIAL_RESET = 4'h2;
	localparam logic [4:0] FUNC_RESET = 5'h07;
	localparam logic [18:0] PHY_WMASK = 19'h4_3FF0;
	localparam int SYNC_STAGES = 3;
	// ----------------------------------------
	// Packet identifiers and CRC residues
	// ----------------------------------------
	localparam logic [3:0] PID_SOF = 4'h5;
	localparam logic [1:0] PID_TYPE_TOKEN = 2'h1;
	localparam logic [1:0] PID_TYPE_DATA = 2'h3;
	localparam logic [4:0] CRC5_INIT = 5'h1F;
	localparam logic [4:0] CRC5_POLY = 5'h14;
	localparam logic [4:0] CRC5_RESIDUE = 5'h06;
	localparam logic [15:0] CRC16_INIT = 16'hFFFF;
	localparam logic [15:0] CRC16_POLY = 16'hA001;
	localparam logic [15:0] CRC16_RESIDUE = 16'hB001;
	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_J = 2'h1;
	localparam logic [1:0] LINE_K = 2'h2;

	typedef struct packed {
		logic [7:0] mode;
		logic [6:0] dev_addr;
		logic [4:0] func;
		logic [7:0] otg;
		logic [3:0] serial;
		logic [6:0] flags;
		logic [6:0] hold;
		logic [31:0] port_mask;
		logic [10:0] sof;
		logic [3:0] pid;
		logic [4:0] endpoint;
		logic [15:0] ep_match;
		logic [31:0] otg_mask;
		logic [8:0] power;
		logic [18:0] phy;
		logic [3:0] port_flag;
		logic [31:0] rdata;
		logic ack;
		logic rx_active_d;
	} mgr_state_t;

	localparam mgr_state_t MGR_RESET = '{func: FUNC_RESET, serial: SERIAL_RESET, default: '0};
endpackage : usb_mgr_pkg

// File: core/usb_level_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module usb_level_sync
	import usb_mgr_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level in and filtered level out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [SYNC_STAGES-1:0][WIDTH-1:0] stage;
		logic [WIDTH-1:0] out;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	if (WIDTH < 1) begin : g_width_check
		$error("usb_level_sync: WIDTH must be at least 1");
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.stage[0] = d;
		s_nxt.stage[1] = s_r.stage[0];
		s_nxt.stage[2] = s_r.stage[1];
		// Only the second and third stages are compared; the first may be metastable
		for (int i = 0; i < WIDTH; i++) begin
			if (s_r.stage[1][i] == s_r.stage[2][i]) begin
				s_nxt.out[i] = s_r.stage[2][i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.out;
endmodule : usb_level_sync
`default_nettype wire

// File: core/usb_packet_checker.sv
// Receive packet parser: PID check, token fields, CRC5 and CRC16
`timescale 1ns/1ps
`default_nettype none
module usb_packet_checker
	import usb_mgr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	// Receive byte stream
	input wire logic rx_active,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	// Decoded results; tok_done and data_crc_bad are pulses
	output logic tok_done,
	output logic tok_crc_ok,
	output logic [3:0] tok_pid,
	output logic [10:0] tok_field,
	output logic data_crc_bad
);
	typedef enum logic [5:0] {
		P_IDLE = 6'b00_0001,
		P_PID = 6'b00_0010,
		P_TOK1 = 6'b00_0100,
		P_TOK2 = 6'b00_1000,
		P_DATA = 6'b01_0000,
		P_SKIP = 6'b10_0000
	} pkt_state_t;

	typedef struct packed {
		pkt_state_t st;
		logic [3:0] pid;
		logic [7:0] byte1;
		logic [4:0] crc5;
		logic [15:0] crc16;
		logic done;
		logic crc_ok;
		logic [10:0] field;
		logic crc_bad;
	} chk_state_t;

	localparam chk_state_t CHK_RESET = '{st: P_IDLE, default: '0};

	chk_state_t s_r;
	chk_state_t s_nxt;

	function automatic logic [4:0] crc5_byte(input logic [4:0] c, input logic [7:0] b);
		logic [4:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC5_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc5_byte

	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc16_byte

	always_comb begin
		logic [4:0] c5;
		c5 = crc5_byte(s_r.crc5, rx_data);
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.crc_bad = 1'b0;
		case (s_r.st)
			P_IDLE: begin
				if (rx_active) s_nxt.st = P_PID;
			end
			P_PID: begin
				if (!rx_active) begin
					s_nxt.st = P_IDLE;
				end else if (rx_valid) begin
					s_nxt.pid = rx_data[3:0];
					s_nxt.crc5 = CRC5_INIT;
					s_nxt.crc16 = CRC16_INIT;
					// PID is valid only when the upper nibble is its complement
					if (rx_data[7:4] != ~rx_data[3:0]) begin
						s_nxt.st = P_SKIP;
					end else if (rx_data[1:0] == PID_TYPE_TOKEN) begin
						s_nxt.st = P_TOK1;
					end else if (rx_data[1:0] == PID_TYPE_DATA) begin
						s_nxt.st = P_DATA;
					end else begin
						s_nxt.st = P_SKIP;
					end
				end
			end
			P_TOK1: begin
				if (!rx_active) begin
					s_nxt.st = P_IDLE;
				end else if (rx_valid) begin
					s_nxt.byte1 = rx_data;
					s_nxt.crc5 = c5;
					s_nxt.st = P_TOK2;
				end
			end
			P_TOK2: begin
				if (!rx_active) begin
					s_nxt.st = P_IDLE;
				end else if (rx_valid) begin
					s_nxt.done = 1'b1;
					s_nxt.crc_ok = (c5 == CRC5_RESIDUE);
					s_nxt.field = {rx_data[2:0], s_r.byte1};
					s_nxt.st = P_SKIP;
				end
			end
			P_DATA: begin
				if (!rx_active) begin
					s_nxt.crc_bad = (s_r.crc16 != CRC16_RESIDUE);
					s_nxt.st = P_IDLE;
				end else if (rx_valid) begin
					s_nxt.crc16 = crc16_byte(s_r.crc16, rx_data);
				end
			end
			P_SKIP: begin
				if (!rx_active) s_nxt.st = P_IDLE;
			end
			default: begin
				s_nxt.st = P_IDLE;
			end
		endcase
		if (clear) s_nxt = CHK_RESET;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= CHK_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tok_done = s_r.done;
	assign tok_crc_ok = s_r.crc_ok;
	assign tok_pid = s_r.pid;
	assign tok_field = s_r.field;
	assign data_crc_bad = s_r.crc_bad;
endmodule : usb_packet_checker
`default_nettype wire

// File: core/usb_interface_manager.sv
// Control and status registers of the USB interface manager facing a UTMI+ transceiver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Any write to the soft-reset register returns all manager state to reset, transceiver untouched.
// - The mode control register holds enables for tokens, checking, line decoding and more, all 0.
// - A 7-bit device address, reset to zero, filters which token packets are passed on.
// - Function control drives operating mode from bits 4:2, TermSelect bit 1, XcvrSelect bit 0, each 1.
// - The on-the-go control register drives pull, VBUS and external VBUS outputs, all reset to 0.
// - The on-the-go status register shows SessEnd, SessVld, VbusVld, HostDisconnect, IdGnd, BValid.
// - Serial control bits 4, 5, 6 read back D+, D- and differential receive inputs.
// - Serial control bit 0 selects serial mode, bit 2 data, bit 3 SE0, bit 1 low-active enable at 1.
// - Flag 6 sets on a token with good PID, good CRC5 and matching address, or on a good SOF when frames count as tokens.
// - Flags 5, 4, 3 set on line state SE0, K and J.
// - Flag 2 sets when a received data packet fails its CRC16.
// - Flags 1 and 0 follow the RxActive and RxError inputs.
// - Flags 6 to 2 clear when the next packet starts unless held, held ones wait for software.
// - Registers are peripheral 1 and are reached only by whole 32-bit reads and writes.
// - A 7-bit hold mask, reset 0, makes each flag stay until a 1 is written to it.
module usb_interface_manager
	import usb_mgr_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Peripheral register access, whole 32-bit words
	input wire logic REG_SEL,
	input wire logic REG_WR,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_ACK,
	// UTMI+ receive path, same clock
	input wire logic UTMI_RXACTIVE,
	input wire logic UTMI_RXVALID,
	input wire logic UTMI_RXERROR,
	input wire logic [7:0] UTMI_DATAOUT,
	// UTMI+ pins from the transceiver, asynchronous
	input wire logic [1:0] UTMI_LINESTATE,
	input wire logic UTMI_SESSEND,
	input wire logic UTMI_SESSVLD,
	input wire logic UTMI_VBUSVLD,
	input wire logic UTMI_HOSTDISCON,
	input wire logic UTMI_IDDIG_GND,
	input wire logic UTMI_BVALID,
	input wire logic UTMI_FS_RXDP,
	input wire logic UTMI_FS_RXDM,
	input wire logic UTMI_FS_RXRCV,
	// UTMI+ function outputs
	output logic [2:0] UTMI_OPMODE,
	output logic UTMI_TERMSELECT,
	output logic UTMI_XCVRSELECT,
	// On-the-go outputs
	output logic ID_PIN_PULLUP,
	output logic UTMI_DPPULLDOWN,
	output logic UTMI_DMPULLDOWN,
	output logic UTMI_DISCHRGVBUS,
	output logic UTMI_CHRGVBUS,
	output logic EXTERNAL_VBUS_DRIVE,
	output logic EXTERNAL_VBUS_INDICATOR,
	// Serial interface outputs
	output logic UTMI_FSLS_SERIAL,
	output logic UTMI_TX_ENABLE_N,
	output logic UTMI_TX_DAT,
	output logic UTMI_TX_SE0,
	// Flags routed through the port masks
	output logic [3:0] PORT_FLAG
);
	mgr_state_t s_r;
	mgr_state_t s_nxt;

	logic [10:0] pins_q;
	logic soft_reset;
	logic tok_done;
	logic tok_crc_ok;
	logic [3:0] tok_pid;
	logic [10:0] tok_field;
	logic data_crc_bad;

	// ----------------------------------------
	// Pin synchronisers and packet checker
	// ----------------------------------------
	usb_level_sync #(
		.WIDTH(11)
	) u_pin_sync (
		.clk(CLOCK),
		.rst_n(RST_N),
		.d({UTMI_FS_RXRCV, UTMI_FS_RXDM, UTMI_FS_RXDP, UTMI_BVALID, UTMI_IDDIG_GND,
			UTMI_HOSTDISCON, UTMI_VBUSVLD, UTMI_SESSVLD, UTMI_SESSEND, UTMI_LINESTATE}),
		.q(pins_q)
	);

	usb_packet_checker u_checker (
		.clk(CLOCK),
		.rst_n(RST_N),
		.clear(soft_reset),
		.rx_active(UTMI_RXACTIVE),
		.rx_valid(UTMI_RXVALID),
		.rx_data(UTMI_DATAOUT),
		.tok_done(tok_done),
		.tok_crc_ok(tok_crc_ok),
		.tok_pid(tok_pid),
		.tok_field(tok_field),
		.data_crc_bad(data_crc_bad)
	);

	wire logic [1:0] line_q = pins_q[1:0];
	wire logic [5:0] otg_q = pins_q[7:2];
	wire logic [2:0] serial_q = pins_q[10:8];
	wire logic wr = REG_SEL & REG_WR;
	wire logic rd = REG_SEL & ~REG_WR;

	assign soft_reset = wr && (REG_ADDR == OFF_SOFT_RESET);

	// ----------------------------------------
	// Event, register and flag update
	// ----------------------------------------
	always_comb begin
		logic [6:0] ev;
		logic [6:0] w1c;
		logic pkt_start;
		logic is_sof;
		logic tok_ok;
		logic tok_pass;
		ev = '0;
		w1c = '0;
		s_nxt = s_r;
		s_nxt.ack = REG_SEL;
		s_nxt.rx_active_d = UTMI_RXACTIVE;
		pkt_start = UTMI_RXACTIVE & ~s_r.rx_active_d;
		is_sof = (tok_pid == PID_SOF);
		// Checking off means CRC5 result is not required
		tok_ok = tok_done & s_r.mode[MODE_TOKEN_PROCESS]
			& (tok_crc_ok | ~s_r.mode[MODE_TOKEN_CHECK]);
		tok_pass = tok_ok & (is_sof ? s_r.mode[MODE_FRAME_AS_TOKEN]
			: (tok_field[6:0] == s_r.dev_addr));
		if (tok_ok && is_sof) s_nxt.sof = tok_field;
		if (tok_pass && !is_sof) begin
			s_nxt.pid = tok_pid;
			s_nxt.endpoint = {1'b1, tok_field[10:7]};
		end

		ev[FLAG_TOKEN] = tok_pass;

		if (s_r.mode[MODE_LINE_DECODE]) begin
			ev[FLAG_SE0] = (line_q == LINE_SE0);
			ev[FLAG_K] = (line_q == LINE_K);
			ev[FLAG_J] = (line_q == LINE_J);
		end

		ev[FLAG_CRC16] = data_crc_bad;
		ev[FLAG_RXACTIVE] = UTMI_RXACTIVE;
		ev[FLAG_RXERROR] = UTMI_RXERROR;

		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		// whole words only
		if (wr) begin
			if (REG_ADDR == OFF_MODE_CTRL) begin
				s_nxt.mode = REG_WDATA[7:0] & MODE_WMASK;
			end else if (REG_ADDR == OFF_DEV_ADDR) begin
				s_nxt.dev_addr = REG_WDATA[6:0];
			end else if (REG_ADDR == OFF_FUNC_CTRL) begin
				s_nxt.func = REG_WDATA[4:0];
			end else if (REG_ADDR == OFF_OTG_CTRL) begin
				s_nxt.otg = REG_WDATA[7:0] & OTG_WMASK;
			end else if (REG_ADDR == OFF_SERIAL) begin
				s_nxt.serial = REG_WDATA[3:0];
			end else if (REG_ADDR == OFF_FLAGS) begin
				w1c = REG_WDATA[6:0];
			end else if (REG_ADDR == OFF_HOLD) begin
				s_nxt.hold = REG_WDATA[6:0];
			end else if (REG_ADDR == OFF_PORT_MASK) begin
				s_nxt.port_mask = REG_WDATA;
			end else if (REG_ADDR == OFF_SOF) begin
				s_nxt.sof = REG_WDATA[10:0];
			end else if (REG_ADDR == OFF_EP_MATCH) begin
				s_nxt.ep_match = REG_WDATA[15:0];
			end else if (REG_ADDR == OFF_OTG_MASK) begin
				s_nxt.otg_mask = REG_WDATA;
			end else if (REG_ADDR == OFF_POWER) begin
				s_nxt.power = REG_WDATA[8:0];
			end else if (REG_ADDR == OFF_PHY_CTRL) begin
				s_nxt.phy = REG_WDATA[18:0] & PHY_WMASK;
			end
		end

		// ----------------------------------------
		// Flag update; a new event beats a clear
		// ----------------------------------------
		for (int i = 0; i < 7; i++) begin
			if (s_r.hold[i]) begin
				s_nxt.flags[i] = ev[i] | (s_r.flags[i] & ~w1c[i]);
			end else if (i == FLAG_RXACTIVE || i == FLAG_RXERROR) begin
				s_nxt.flags[i] = ev[i];
			end else begin
				s_nxt.flags[i] = ev[i] | (s_r.flags[i] & ~w1c[i] & ~pkt_start);
			end
		end
		for (int p = 0; p < 4; p++) begin
			s_nxt.port_flag[p] = |(s_r.port_mask[8*p +: 7] & s_r.flags);
		end

		// ----------------------------------------
		// Read data, unmapped reads return zero
		// ----------------------------------------
		s_nxt.rdata = '0;
		if (rd) begin
			if (REG_ADDR == OFF_MODE_CTRL) begin
				s_nxt.rdata[7:0] = s_r.mode;
			end else if (REG_ADDR == OFF_DEV_ADDR) begin
				s_nxt.rdata[6:0] = s_r.dev_addr;
			end else if (REG_ADDR == OFF_FUNC_CTRL) begin
				s_nxt.rdata[4:0] = s_r.func;
			end else if (REG_ADDR == OFF_OTG_CTRL) begin
				s_nxt.rdata[7:0] = s_r.otg;
			end else if (REG_ADDR == OFF_OTG_STAT) begin
				s_nxt.rdata[5:0] = otg_q;
			end else if (REG_ADDR == OFF_SERIAL) begin
				s_nxt.rdata[6:0] = {serial_q, s_r.serial};
			end else if (REG_ADDR == OFF_FLAGS) begin
				s_nxt.rdata[6:0] = s_r.flags;
			end else if (REG_ADDR == OFF_HOLD) begin
				s_nxt.rdata[6:0] = s_r.hold;
			end else if (REG_ADDR == OFF_PORT_MASK) begin
				s_nxt.rdata = s_r.port_mask;
			end else if (REG_ADDR == OFF_SOF) begin
				s_nxt.rdata[10:0] = s_r.sof;
			end else if (REG_ADDR == OFF_PID) begin
				s_nxt.rdata[3:0] = s_r.pid;
			end else if (REG_ADDR == OFF_ENDPOINT) begin
				s_nxt.rdata[4:0] = s_r.endpoint;
			end else if (REG_ADDR == OFF_EP_MATCH) begin
				s_nxt.rdata[15:0] = s_r.ep_match;
			end else if (REG_ADDR == OFF_OTG_MASK) begin
				s_nxt.rdata = s_r.otg_mask;
			end else if (REG_ADDR == OFF_POWER) begin
				s_nxt.rdata[8:0] = s_r.power;
			end else if (REG_ADDR == OFF_PHY_CTRL) begin
				s_nxt.rdata[18:0] = s_r.phy;
			end
		end

		// manager state only, the pin synchroniser keeps its stages
		if (soft_reset) begin
			s_nxt = MGR_RESET;
			s_nxt.ack = 1'b1;
			s_nxt.rx_active_d = UTMI_RXACTIVE;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			s_r <= MGR_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign REG_RDATA = s_r.rdata;
	assign REG_ACK = s_r.ack;

	assign UTMI_OPMODE = s_r.func[4:2];
	assign UTMI_TERMSELECT = s_r.func[1];
	assign UTMI_XCVRSELECT = s_r.func[0];

	assign ID_PIN_PULLUP = s_r.otg[0];
	assign UTMI_DPPULLDOWN = s_r.otg[1];
	assign UTMI_DMPULLDOWN = s_r.otg[2];
	assign UTMI_DISCHRGVBUS = s_r.otg[3];
	assign UTMI_CHRGVBUS = s_r.otg[4];
	assign EXTERNAL_VBUS_DRIVE = s_r.otg[6];
	assign EXTERNAL_VBUS_INDICATOR = s_r.otg[7];

	assign UTMI_FSLS_SERIAL = s_r.serial[0];
	assign UTMI_TX_ENABLE_N = s_r.serial[1];
	assign UTMI_TX_DAT = s_r.serial[2];
	assign UTMI_TX_SE0 = s_r.serial[3];

	assign PORT_FLAG = s_r.port_flag;
endmodule : usb_interface_manager
`default_nettype wire

// File: verif/usb_interface_manager_checker.sv
// Assertions on the register port and UTMI+ control outputs
`timescale 1ns/1ps
`default_nettype none
module usb_interface_manager_checker
	import usb_mgr_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Register port
	input wire logic REG_SEL,
	input wire logic REG_WR,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic REG_ACK,
	// UTMI+ control outputs
	input wire logic [2:0] UTMI_OPMODE,
	input wire logic UTMI_TERMSELECT,
	input wire logic UTMI_XCVRSELECT,
	input wire logic ID_PIN_PULLUP,
	input wire logic UTMI_DPPULLDOWN,
	input wire logic UTMI_DMPULLDOWN,
	input wire logic UTMI_DISCHRGVBUS,
	input wire logic UTMI_CHRGVBUS,
	input wire logic EXTERNAL_VBUS_DRIVE,
	input wire logic EXTERNAL_VBUS_INDICATOR,
	input wire logic UTMI_FSLS_SERIAL,
	input wire logic UTMI_TX_ENABLE_N,
	input wire logic UTMI_TX_DAT,
	input wire logic UTMI_TX_SE0
);
	wire logic wr_en = REG_SEL && REG_WR;
	wire logic rd_en = REG_SEL && !REG_WR;
	wire logic [4:0] func_out = {UTMI_OPMODE, UTMI_TERMSELECT, UTMI_XCVRSELECT};
	wire logic [6:0] otg_out = {EXTERNAL_VBUS_INDICATOR, EXTERNAL_VBUS_DRIVE, UTMI_CHRGVBUS,
		UTMI_DISCHRGVBUS, UTMI_DMPULLDOWN, UTMI_DPPULLDOWN, ID_PIN_PULLUP};
	wire logic [3:0] ser_out = {UTMI_TX_SE0, UTMI_TX_DAT, UTMI_TX_ENABLE_N, UTMI_FSLS_SERIAL};
	wire logic [4:0] wd_func = REG_WDATA[4:0];
	wire logic [6:0] wd_otg = {REG_WDATA[7:6], REG_WDATA[4:0]};
	wire logic [3:0] wd_ser = REG_WDATA[3:0];

	default clocking main_cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	a_ack_follows: assert property (REG_SEL |=> REG_ACK)
		else $error("no ack after access");
	a_no_stray: assert property (!REG_SEL |=> !REG_ACK)
		else $error("ack without access");
	a_idle_rdata: assert property (!REG_ACK |-> REG_RDATA == 32'h0)
		else $error("read data outside ack");
	a_func_write: assert property (wr_en && REG_ADDR == OFF_FUNC_CTRL |=> func_out == $past(wd_func))
		else $error("function outputs differ from write");
	a_func_hold: assert property (!wr_en [*2] |=> $stable(func_out))
		else $error("function outputs moved without write");
	a_otg_write: assert property (wr_en && REG_ADDR == OFF_OTG_CTRL |=> otg_out == $past(wd_otg))
		else $error("otg outputs differ from write");
	a_serial_write: assert property (wr_en && REG_ADDR == OFF_SERIAL |=> ser_out == $past(wd_ser))
		else $error("serial outputs differ from write");
	a_soft_reset: assert property (wr_en && REG_ADDR == OFF_SOFT_RESET |-> ##[1:2]
		(func_out == FUNC_RESET && otg_out == 7'h0 && ser_out == SERIAL_RESET))
		else $error("outputs not reset by soft reset");
	a_status_top: assert property (rd_en && REG_ADDR == OFF_OTG_STAT |=> REG_RDATA[31:6] == 26'h0)
		else $error("status reserved bits set");
	a_unmapped_zero: assert property (rd_en && (REG_ADDR > OFF_PHY_CTRL || REG_ADDR[1:0] != 2'h0)
		|=> REG_RDATA == 32'h0)
		else $error("unmapped read not zero");
endmodule : usb_interface_manager_checker

bind usb_interface_manager usb_interface_manager_checker checker_i (
	.CLOCK, .RST_N, .REG_SEL, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_ACK,
	.UTMI_OPMODE, .UTMI_TERMSELECT, .UTMI_XCVRSELECT, .ID_PIN_PULLUP, .UTMI_DPPULLDOWN,
	.UTMI_DMPULLDOWN, .UTMI_DISCHRGVBUS, .UTMI_CHRGVBUS, .EXTERNAL_VBUS_DRIVE,
	.EXTERNAL_VBUS_INDICATOR, .UTMI_FSLS_SERIAL, .UTMI_TX_ENABLE_N, .UTMI_TX_DAT, .UTMI_TX_SE0
);
`default_nettype wire

// File: verif/usb_phy_model.sv
// Behavioural UTMI+ transceiver: receive byte stream and status pins
`timescale 1ns/1ps
`default_nettype none
module usb_phy_model (
	// Clock
	input wire logic clk,
	// Receive path
	output logic rx_active,
	output logic rx_valid,
	output logic rx_error,
	output logic [7:0] data_out,
	// Status pins
	output logic [1:0] line_state,
	output logic [5:0] otg,
	output logic [2:0] fs
);
	logic [7:0] q[$];
	logic act_r;
	logic hold;
	logic slow;
	initial begin
		{act_r, hold, slow, rx_valid, rx_error, line_state, otg, fs} = '0;
		data_out = 8'h5A;
	end
	assign rx_active = act_r | hold;
	// Idle data keeps changing so a stale byte never passes as valid
	always @(negedge clk) begin
		if (!act_r) begin
			data_out <= ~data_out;
			if (q.size() != 0) act_r <= 1'b1;
		end else if (q.size() == 0) begin
			act_r <= 1'b0;
			rx_valid <= 1'b0;
			data_out <= ~data_out;
		end else if (slow && rx_valid) begin
			rx_valid <= 1'b0;
			data_out <= ~data_out;
		end else begin
			rx_valid <= 1'b1;
			data_out <= q.pop_front();
		end
	end
	task automatic send(input logic [23:0] p);
		for (int i = 2; i >= 0; i--) q.push_back(p[8*i +: 8]);
		for (int i = 0; i < 20 && (q.size() != 0 || act_r); i++) @(negedge clk);
	endtask : send
endmodule : usb_phy_model
`default_nettype wire

// File: verif/usb_interface_manager_tb.sv
// Self-checking bench for the USB interface manager registers
`timescale 1ns/1ps
`default_nettype none
module usb_interface_manager_tb
	import usb_mgr_pkg::*;
;
	typedef struct packed {
		logic chk;
		logic [7:0] adr;
		logic [31:0] val;
	} note_t;
	localparam logic [7:0] wa [12] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28,
		8'h34, 8'h38, 8'h3C, 8'h40};
	localparam logic [31:0] wm [12] = '{32'hF7, 32'h7F, 32'h1F, 32'hDF, 32'hF, 32'h7F,
		32'hFFFF_FFFF, 32'h7FF, 32'hFFFF, 32'hFFFF_FFFF, 32'h1FF, 32'h4_3FF0};
	localparam logic [7:0] ro [3] = '{8'h14, 8'h2C, 8'h30};
	localparam int lbit [3] = '{5, 3, 4};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sel = 1'b0;
	logic wr = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] lfsr = 32'h548f;
	wire logic [31:0] rdat;
	wire logic ack, rxa, rxv, rxe;
	wire logic [7:0] rxd;
	wire logic [1:0] ls;
	wire logic [5:0] otg;
	wire logic [2:0] fs;
	wire logic [3:0] pf;
	note_t notes[$];
	note_t n;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;

	usb_interface_manager DUT (
		.CLOCK(clk), .RST_N(rst_n), .REG_SEL(sel), .REG_WR(wr), .REG_ADDR(adr),
		.REG_WDATA(wdat), .REG_RDATA(rdat), .REG_ACK(ack),
		.UTMI_RXACTIVE(rxa), .UTMI_RXVALID(rxv), .UTMI_RXERROR(rxe), .UTMI_DATAOUT(rxd),
		.UTMI_LINESTATE(ls), .UTMI_SESSEND(otg[0]), .UTMI_SESSVLD(otg[1]),
		.UTMI_VBUSVLD(otg[2]), .UTMI_HOSTDISCON(otg[3]), .UTMI_IDDIG_GND(otg[4]),
		.UTMI_BVALID(otg[5]), .UTMI_FS_RXDP(fs[0]), .UTMI_FS_RXDM(fs[1]), .UTMI_FS_RXRCV(fs[2]),
		.UTMI_OPMODE(), .UTMI_TERMSELECT(), .UTMI_XCVRSELECT(), .ID_PIN_PULLUP(),
		.UTMI_DPPULLDOWN(), .UTMI_DMPULLDOWN(), .UTMI_DISCHRGVBUS(), .UTMI_CHRGVBUS(),
		.EXTERNAL_VBUS_DRIVE(), .EXTERNAL_VBUS_INDICATOR(), .UTMI_FSLS_SERIAL(),
		.UTMI_TX_ENABLE_N(), .UTMI_TX_DAT(), .UTMI_TX_SE0(), .PORT_FLAG(pf)
	);
	usb_phy_model phy (
		.clk(clk), .rx_active(rxa), .rx_valid(rxv), .rx_error(rxe), .data_out(rxd),
		.line_state(ls), .otg(otg), .fs(fs)
	);

	always #20 clk = ~clk;

	function automatic logic [31:0] rand32();
		lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
		return lfsr;
	endfunction : rand32

	// Token bytes with CRC5 sent low bit first; bad flips one CRC bit
	function automatic logic [23:0] token(input logic [6:0] a, input logic [3:0] e, input logic bad);
		logic [10:0] f;
		logic [4:0] r;
		f = {e, a};
		r = 5'h1F;
		for (int i = 0; i < 11; i++) r = (r[0] ^ f[i]) ? (r >> 1) ^ 5'h14 : r >> 1;
		r = ~r ^ {4'h0, bad};
		return {8'hE1, f[7:0], r, f[10:8]};
	endfunction : token

	task automatic check_word(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("mismatch reg %h expected %h seen %h", a, e, g);
		end
	endtask : check_word

	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		@(negedge clk);
		sel = 1'b1;
		wr = w;
		adr = a;
		wdat = d;
		notes.push_back('{c, a, d});
	endtask : access

	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		access(1'b1, a, d, 1'b0);
	endtask : wrt

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		access(1'b0, a, e, 1'b1);
	endtask : rd

	task automatic pause(input int k);
		@(negedge clk);
		sel = 1'b0;
		repeat (k) @(negedge clk);
	endtask : pause

	task automatic section(input string s);
		pause(0);
		for (int i = 0; i < 8 && notes.size() != 0; i++) @(negedge clk);
		$display("test %s done", s);
	endtask : section

	task automatic chk_all();
		for (logic [7:0] a = 8'h04; a <= 8'h44; a += 8'h04)
			rd(a, a == OFF_FUNC_CTRL ? 32'h7 : a == OFF_SERIAL ? 32'h2 : 32'h0);
		rd(8'h02, 32'h0);
	endtask : chk_all

	task automatic test_done();
		if (notes.size() != 0) errors++;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// Read data is matched to the oldest note when its ack shows
	always @(negedge clk) begin
		if (rst_n && ack === 1'b1) begin
			if (notes.size() == 0) begin
				errors++;
				$display("mismatch ack expected 0 seen 1");
			end else begin
				n = notes.pop_front();
				if (n.chk) check_word(n.adr, n.val, rdat);
			end
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		logic [31:0] d;
		logic [6:0] a7;
		logic [3:0] ep;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk_all();
		for (int i = 0; i < 12; i++) begin
			d = rand32();
			wrt(wa[i], d);
			rd(wa[i], d & wm[i]);
		end
		foreach (ro[i]) begin
			wrt(ro[i], 32'hFFFF_FFFF);
			rd(ro[i], 32'h0);
		end
		wrt(OFF_SOFT_RESET, rand32());
		chk_all();
		section("registers");
		for (int i = 0; i < 4; i++) begin
			d = rand32();
			phy.otg = d[5:0];
			phy.fs = d[8:6];
			pause(6);
			rd(OFF_OTG_STAT, {26'h0, d[5:0]});
			rd(OFF_SERIAL, {25'h0, d[8:6], 4'h2});
		end
		phy.otg = 6'h0;
		section("status");
		wrt(OFF_MODE_CTRL, 32'h4);
		for (int i = 0; i < 3; i++) begin
			phy.line_state = i[1:0];
			pause(6);
			wrt(OFF_FLAGS, 32'h7F);
			rd(OFF_FLAGS, 32'h1 << lbit[i]);
		end
		phy.line_state = 2'h1;
		wrt(OFF_MODE_CTRL, 32'h3);
		wrt(OFF_FLAGS, 32'h7F);
		section("line");
		phy.hold = 1'b1;
		phy.rx_error = 1'b1;
		pause(2);
		rd(OFF_FLAGS, 32'h3);
		phy.hold = 1'b0;
		phy.rx_error = 1'b0;
		pause(2);
		rd(OFF_FLAGS, 32'h0);
		section("rx");
		d = rand32();
		a7 = d[6:0] | 7'h1;
		ep = d[10:7];
		wrt(OFF_DEV_ADDR, {25'h0, a7});
		for (int i = 0; i < 5; i++) begin
			wrt(OFF_HOLD, {25'h0, 1'(5'b11000 >> i), 6'h0});
			pause(0);
			phy.slow = i[0];
			phy.send(token(a7 ^ {6'h0, 1'(5'b10010 >> i)}, ep, 1'(5'b00100 >> i)));
			pause(3);
			rd(OFF_FLAGS, {25'h0, 1'(5'b11001 >> i), 6'h0});
		end
		wrt(OFF_FLAGS, 32'h40);
		rd(OFF_FLAGS, 32'h0);
		rd(OFF_PID, 32'h1);
		rd(OFF_ENDPOINT, {27'h0, 1'b1, ep});
		section("token");
		wrt(OFF_HOLD, 32'h0);
		pause(0);
		phy.send(24'hC3_0001);
		pause(3);
		rd(OFF_FLAGS, 32'h4);
		pause(0);
		phy.send(24'hC3_0000);
		pause(3);
		rd(OFF_FLAGS, 32'h0);
		wrt(OFF_PORT_MASK, 32'h4000_0000);
		wrt(OFF_MODE_CTRL, 32'h43);
		d[23:0] = token(a7, ep, 1'b0);
		pause(0);
		phy.send({8'hA5, d[15:0]});
		pause(3);
		check_word(8'h24, 32'h8, {28'h0, pf});
		rd(OFF_SOF, {21'h0, ep, a7});
		section("crc16");
		test_done();
	end
endmodule : usb_interface_manager_tb
`default_nettype wire
